// file: hdl/usrc_fw.sv
// Firmware end: services suspend and resume interrupts, sets the
// configured and address bits. Assumes the device answers reads next cycle.
`include "usrc_map.svh"
`timescale 1ns/1ps
module usrc_fw
   import usrc_pkg::*;
(
   // Clock and reset
   input  wire logic       I_REF_CLK,
   input  wire logic       I_RST,
   // Device link
   usrc_if.fw              DEV,
   // Requests
   input  wire logic       I_SET_CONFIG,
   input  wire logic [7:0] I_CONFIG_VALUE,
   input  wire logic       I_ADDR_DONE,
   input  wire logic       I_USE_WAKE_PIN,
   // Status
   output logic            O_BUSY,
   output logic            O_PERIPH_EN,
   output logic            O_GPIO_LOWPWR,
   output logic            O_SLEEP_EN,
   output logic [1:0]      O_SLEEP_MODE
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   usrc_fw_state_t state_r, state_nxt;
   usrc_addr_t     addr_r,  addr_nxt;
   usrc_byte_t     wdata_r, wdata_nxt;
   logic           wr_r,    wr_nxt;
   logic           rd_r,    rd_nxt;
   logic           slp_r,   slp_nxt;
   logic           cfg_r,   cfg_nxt;
   logic           adr_r,   adr_nxt;
   logic           per_r,   per_nxt;
   logic           gpio_r,  gpio_nxt;
   logic           se_r,    se_nxt;
   logic [1:0]     sm_r,    sm_nxt;
   logic           asleep_r, asleep_nxt;
   logic           wused_r, wused_nxt;
   logic           init_r,  init_nxt;
   logic           busy_r,  busy_nxt;
   logic [2:0]     ev;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt  = state_r;
      addr_nxt   = addr_r;
      wdata_nxt  = wdata_r;
      wr_nxt     = 1'b0;
      rd_nxt     = 1'b0;
      slp_nxt    = 1'b0;
      cfg_nxt    = cfg_r;
      adr_nxt    = adr_r;
      per_nxt    = per_r;
      gpio_nxt   = gpio_r;
      se_nxt     = se_r;
      sm_nxt     = sm_r;
      asleep_nxt = asleep_r;
      wused_nxt  = wused_r;
      init_nxt   = init_r;
      ev         = DEV.rdata[2:0];
      unique case (state_r)
         FS_IDLE: begin
            if (!init_r) begin
               // Enables go in first, else no event would reach the handler
               init_nxt  = 1'b1;
               addr_nxt  = `USRC_IEN_ADDR;
               wdata_nxt = `USRC_IEN_MASK;
               wr_nxt    = 1'b1;
            end else if (DEV.irq) begin
               addr_nxt  = `USRC_EVT_ADDR;
               rd_nxt    = 1'b1;
               state_nxt = FS_RD;
            end else if (I_SET_CONFIG) begin
               cfg_nxt   = (I_CONFIG_VALUE != 8'h00);
               addr_nxt  = `USRC_GLB_ADDR;
               wdata_nxt = {6'h00, (I_CONFIG_VALUE != 8'h00), adr_r};
               wr_nxt    = 1'b1;
            end else if (I_ADDR_DONE) begin
               adr_nxt   = 1'b1;
               addr_nxt  = `USRC_GLB_ADDR;
               wdata_nxt = {6'h00, cfg_r, 1'b1};
               wr_nxt    = 1'b1;
            end
         end
         FS_RD: state_nxt = FS_CAP;
         FS_CAP: begin
            if (ev[`USRC_EV_RSM_BIT]) begin
               addr_nxt  = `USRC_EVT_ADDR;
               wdata_nxt = {5'h00, ev};
               wr_nxt    = 1'b1;
               state_nxt = FS_RESTORE;
            end else if (ev[`USRC_EV_SUSP_BIT] && !asleep_r) begin
               per_nxt   = 1'b0;
               state_nxt = FS_SUSP;
            end else if (asleep_r) begin
               // Poll while asleep; the suspend event keeps the line high
               addr_nxt  = `USRC_EVT_ADDR;
               rd_nxt    = 1'b1;
               state_nxt = FS_RD;
            end else begin
               state_nxt = FS_IDLE;
            end
         end
         FS_SUSP: begin
            se_nxt   = 1'b1;
            sm_nxt   = `USRC_SM_PDOWN;
            gpio_nxt = 1'b1;
            if (I_USE_WAKE_PIN) begin
               wused_nxt = 1'b1;
               addr_nxt  = `USRC_OVC_ADDR;
               wdata_nxt = 8'h01 << `USRC_OVC_WAKE_BIT;
               wr_nxt    = 1'b1;
            end
            state_nxt = FS_SLEEP;
         end
         FS_SLEEP: begin
            slp_nxt    = 1'b1;
            asleep_nxt = 1'b1;
            // Read back the state register beside the sleep request
            addr_nxt   = `USRC_GLB_ADDR;
            rd_nxt     = 1'b1;
            state_nxt  = FS_ZZZ;
         end
         FS_ZZZ: begin
            addr_nxt  = `USRC_EVT_ADDR;
            rd_nxt    = 1'b1;
            state_nxt = FS_RD;
         end
         FS_RESTORE: begin
            gpio_nxt   = 1'b0;
            se_nxt     = 1'b0;
            asleep_nxt = 1'b0;
            if (wused_r) begin
               wused_nxt = 1'b0;
               addr_nxt  = `USRC_OVC_ADDR;
               wdata_nxt = 8'h00;
               wr_nxt    = 1'b1;
            end
            state_nxt = FS_ENABLE;
         end
         FS_ENABLE: begin
            per_nxt   = 1'b1;
            addr_nxt  = `USRC_GLB_ADDR;
            rd_nxt    = 1'b1;
            state_nxt = FS_IDLE;
         end
      endcase
      busy_nxt = (state_nxt != FS_IDLE);
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         state_r  <= FS_IDLE;
         addr_r   <= '0;
         wdata_r  <= `USRC_RESET_VAL;
         wr_r     <= 1'b0;
         rd_r     <= 1'b0;
         slp_r    <= 1'b0;
         cfg_r    <= 1'b0;
         adr_r    <= 1'b0;
         per_r    <= 1'b1;
         gpio_r   <= 1'b0;
         se_r     <= 1'b0;
         sm_r     <= 2'h0;
         asleep_r <= 1'b0;
         wused_r  <= 1'b0;
         init_r   <= 1'b0;
         busy_r   <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         addr_r   <= addr_nxt;
         wdata_r  <= wdata_nxt;
         wr_r     <= wr_nxt;
         rd_r     <= rd_nxt;
         slp_r    <= slp_nxt;
         cfg_r    <= cfg_nxt;
         adr_r    <= adr_nxt;
         per_r    <= per_nxt;
         gpio_r   <= gpio_nxt;
         se_r     <= se_nxt;
         sm_r     <= sm_nxt;
         asleep_r <= asleep_nxt;
         wused_r  <= wused_nxt;
         init_r   <= init_nxt;
         busy_r   <= busy_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign DEV.addr      = addr_r;
   assign DEV.wdata     = wdata_r;
   assign DEV.wr        = wr_r;
   assign DEV.rd        = rd_r;
   assign DEV.sleep     = slp_r;
   assign O_BUSY        = busy_r;
   assign O_PERIPH_EN   = per_r;
   assign O_GPIO_LOWPWR = gpio_r;
   assign O_SLEEP_EN    = se_r;
   assign O_SLEEP_MODE  = sm_r;
endmodule : usrc_fw

// file: hdl/usrc_map.svh
// Offsets, field positions, reset values and timing counts of the
// suspend/resume controller. Assumes a 200 MHz reference clock.
`ifndef USRC_MAP_SVH
`define USRC_MAP_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define USRC_AW              13
`define USRC_GLB_ADDR        13'h1ffb
`define USRC_EVT_ADDR        13'h1ff0
`define USRC_IEN_ADDR        13'h1ff1
`define USRC_OVC_ADDR        13'h1ff2
// ---------------------------------------------------------------
// Field positions and masks
// ---------------------------------------------------------------
`define USRC_GLOBAL_SUSPEND_EVENT_BIT    4
`define USRC_GLB_RES_BIT     3
`define USRC_GLB_CFG_BIT     1
`define USRC_GLB_ADR_BIT     0
`define USRC_EV_SUSP_BIT     0
`define USRC_EV_RSM_BIT      1
`define USRC_EV_RWU_BIT      2
`define USRC_IEN_RWU_BIT     7
`define USRC_IEN_MASK        8'h87
`define USRC_OVC_WAKE_BIT    2
`define USRC_RESET_VAL       8'h00
`define USRC_SM_PDOWN        2'h2
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define USRC_CLK_MHZ         200
`define USRC_IDLE_MS         3
`define USRC_IDLE_CYC        (`USRC_IDLE_MS * `USRC_CLK_MHZ * 1000)
`define USRC_RWU_US          1000
`define USRC_RWU_CYC         (`USRC_RWU_US * `USRC_CLK_MHZ)
`endif

// file: hdl/usrc_pkg.sv
// Types shared by both ends of the suspend/resume controller.
// Assumes usrc_map.svh for all numeric constants.
package usrc_pkg;
   typedef logic [12:0] usrc_addr_t;
   typedef logic [7:0]  usrc_byte_t;
   typedef enum logic [2:0] {
      DS_ACTIVE, DS_SUSP, DS_SLEEP, DS_HRES, DS_RWU
   } usrc_dev_state_t;
   typedef enum logic [3:0] {
      FS_IDLE, FS_RD, FS_CAP, FS_SUSP, FS_SLEEP, FS_ZZZ, FS_RESTORE, FS_ENABLE
   } usrc_fw_state_t;
endpackage : usrc_pkg

// file: hdl/usrc_if.sv
// Register and sleep link between the controller and its firmware end.
// Assumes both ends run on the same clock; no clocking block.
`timescale 1ns/1ps
interface usrc_if;
   import usrc_pkg::*;
   usrc_addr_t addr;
   usrc_byte_t wdata;
   logic       wr;
   logic       rd;
   logic       sleep;
   usrc_byte_t rdata;
   logic       irq;
   modport dev (input addr, input wdata, input wr, input rd, input sleep,
                output rdata, output irq);
   modport fw  (output addr, output wdata, output wr, output rd, output sleep,
                input rdata, input irq);
endinterface : usrc_if

// file: hdl/usrc_dev.sv
// Device end: suspend detect, resume and remote wakeup, clock gating,
// global state register. Assumes all inputs synchronous to I_REF_CLK.
//
// Notes on behaviour
// - Suspend indicator high while suspended, read only.
// - Resume indicator set during resume, read only.
// - Configured flag written by firmware, reset clears.
// - Address applies from next transaction after enable.
// - Global state bits 7..5 and 2 read zero.
// - Idle 3 ms sets suspend event, interrupts.
// - Sleep while suspended stops oscillator and PLL.
// - Bus activity or external interrupt restarts operation.
// - Host resume restarts oscillator, sets resume event.
// - Enabled external interrupt drives remote wakeup upstream.
// - Overcurrent register bit 2 enables wake pin.
// - Low wake pin during suspend triggers resume.
// - Firmware stops peripherals then executes sleep.
// - Firmware clears events after host resume.
// - Firmware clears events after remote wakeup.
`include "usrc_map.svh"
`timescale 1ns/1ps
module usrc_dev
   import usrc_pkg::*;
#(
   parameter int IDLE_CYC = `USRC_IDLE_CYC,
   parameter int RWU_CYC  = `USRC_RWU_CYC
) (
   // Clock and reset
   input  wire logic I_REF_CLK,
   input  wire logic I_RST,
   // Firmware link
   usrc_if.dev       FW,
   // USB bus
   input  wire logic I_BUS_IDLE,
   input  wire logic I_HOST_RESUME,
   input  wire logic I_TXN_START,
   output logic      O_RESUME_DRIVE,
   output logic      O_ADDR_ACTIVE,
   output logic      O_CONFIGURED,
   // Wake sources
   input  wire logic I_EXT_IRQ_ZERO,
   input  wire logic I_EXT_IRQ_ONE,
   input  wire logic I_WAKE_PIN_N,
   // Clock gating
   output logic      O_OSC_EN,
   output logic      O_PLL_EN
);
   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   localparam int MAXC = (IDLE_CYC > RWU_CYC) ? IDLE_CYC : RWU_CYC;
   localparam int CW   = $clog2(MAXC + 1);
   if (IDLE_CYC < 1 || RWU_CYC < 1) begin : g_bad
      $error("usrc_dev: cycle counts must be at least one");
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   usrc_dev_state_t state_r,  state_nxt;
   logic [CW-1:0]   cnt_r,    cnt_nxt;
   logic            cfg_r,    cfg_nxt;
   logic            adr_r,    adr_nxt;
   logic            act_r,    act_nxt;
   logic [2:0]      ev_r,     ev_nxt;
   usrc_byte_t      ien_r,    ien_nxt;
   logic            ovc_r,    ovc_nxt;
   usrc_byte_t      rdata_r,  rdata_nxt;
   logic            irq_r,    irq_nxt;
   logic            osc_r,    osc_nxt;
   logic            drv_r,    drv_nxt;
   logic [2:0]      ev_set;
   logic [2:0]      ev_clr;
   logic            susp_ind;
   logic            res_ind;
   logic            rwu_src;
   logic            ext_irq;
   usrc_byte_t      glb_rd;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      cfg_nxt   = cfg_r;
      adr_nxt   = adr_r;
      ien_nxt   = ien_r;
      ovc_nxt   = ovc_r;
      rdata_nxt = rdata_r;
      ev_set    = 3'h0;
      ev_clr    = 3'h0;
      ext_irq   = I_EXT_IRQ_ZERO | I_EXT_IRQ_ONE;
      rwu_src   = (ien_r[`USRC_IEN_RWU_BIT] & ext_irq)
                | (ovc_r & ~I_WAKE_PIN_N);
      susp_ind  = (state_r == DS_SUSP) || (state_r == DS_SLEEP);
      res_ind   = (state_r == DS_HRES) || (state_r == DS_RWU);

      unique case (state_r)
         DS_ACTIVE: begin
            if (I_BUS_IDLE) begin
               if (cnt_r == CW'(IDLE_CYC - 1)) begin
                  state_nxt                = DS_SUSP;
                  ev_set[`USRC_EV_SUSP_BIT] = 1'b1;
                  cnt_nxt                  = '0;
               end else begin
                  cnt_nxt = cnt_r + 1'b1;
               end
            end else begin
               cnt_nxt = '0;
            end
         end
         DS_SUSP, DS_SLEEP: begin
            cnt_nxt = '0;
            if (I_HOST_RESUME) begin
               state_nxt               = DS_HRES;
               ev_set[`USRC_EV_RSM_BIT] = 1'b1;
            end else if (rwu_src) begin
               state_nxt               = DS_RWU;
               ev_set[`USRC_EV_RSM_BIT] = 1'b1;
               ev_set[`USRC_EV_RWU_BIT] = 1'b1;
            end else if (!I_BUS_IDLE || ext_irq) begin
               state_nxt = DS_ACTIVE;
            end else if (state_r == DS_SUSP && FW.sleep) begin
               state_nxt = DS_SLEEP;
            end
         end
         DS_HRES: begin
            // Flag drops only once the host stops resume signalling
            if (!I_HOST_RESUME) begin
               state_nxt = DS_ACTIVE;
            end
         end
         DS_RWU: begin
            if (cnt_r == CW'(RWU_CYC - 1)) begin
               state_nxt = DS_ACTIVE;
               cnt_nxt   = '0;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
      endcase

      // Register writes
      if (FW.wr) begin
         unique case (FW.addr)
            `USRC_GLB_ADDR: begin
               cfg_nxt = FW.wdata[`USRC_GLB_CFG_BIT];
               adr_nxt = FW.wdata[`USRC_GLB_ADR_BIT];
            end
            `USRC_EVT_ADDR: ev_clr  = FW.wdata[2:0];
            `USRC_IEN_ADDR: ien_nxt = FW.wdata & `USRC_IEN_MASK;
            `USRC_OVC_ADDR: ovc_nxt = FW.wdata[`USRC_OVC_WAKE_BIT];
            default: ;
         endcase
      end

      // Set wins over a clear in the same cycle
      ev_nxt = (ev_r & ~ev_clr) | ev_set;

      // Register reads, answered one cycle later
      glb_rd = 8'h00;
      glb_rd[`USRC_GLOBAL_SUSPEND_EVENT_BIT] = susp_ind;
      glb_rd[`USRC_GLB_RES_BIT]  = res_ind;
      glb_rd[`USRC_GLB_CFG_BIT]  = cfg_r;
      glb_rd[`USRC_GLB_ADR_BIT]  = adr_r;
      if (FW.rd) begin
         unique case (FW.addr)
            `USRC_GLB_ADDR: rdata_nxt = glb_rd;
            `USRC_EVT_ADDR: rdata_nxt = {5'h00, ev_r};
            `USRC_IEN_ADDR: rdata_nxt = ien_r;
            `USRC_OVC_ADDR: rdata_nxt = {5'h00, ovc_r, 2'h0};
            default:        rdata_nxt = 8'h00;
         endcase
      end

      // New address takes effect at a transaction boundary
      if (!adr_r) begin
         act_nxt = 1'b0;
      end else if (I_TXN_START) begin
         act_nxt = 1'b1;
      end else begin
         act_nxt = act_r;
      end

      irq_nxt = |(ev_nxt & ien_r[2:0]);
      osc_nxt = (state_nxt != DS_SLEEP);
      drv_nxt = (state_nxt == DS_RWU);
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         state_r <= DS_ACTIVE;
         cnt_r   <= '0;
         cfg_r   <= 1'b0;
         adr_r   <= 1'b0;
         act_r   <= 1'b0;
         ev_r    <= 3'h0;
         ien_r   <= `USRC_RESET_VAL;
         ovc_r   <= 1'b0;
         rdata_r <= `USRC_RESET_VAL;
         irq_r   <= 1'b0;
         osc_r   <= 1'b1;
         drv_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         cfg_r   <= cfg_nxt;
         adr_r   <= adr_nxt;
         act_r   <= act_nxt;
         ev_r    <= ev_nxt;
         ien_r   <= ien_nxt;
         ovc_r   <= ovc_nxt;
         rdata_r <= rdata_nxt;
         irq_r   <= irq_nxt;
         osc_r   <= osc_nxt;
         drv_r   <= drv_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Oscillator and PLL share one flop so they can never disagree
   assign FW.rdata       = rdata_r;
   assign FW.irq         = irq_r;
   assign O_RESUME_DRIVE = drv_r;
   assign O_ADDR_ACTIVE  = act_r;
   assign O_CONFIGURED   = cfg_r;
   assign O_OSC_EN       = osc_r;
   assign O_PLL_EN       = osc_r;
endmodule : usrc_dev

// file: verif/usrc_assertions.sv
// Checker for the suspend/resume controller and its firmware link.
// Assumes the interface signals and device pins as plain inputs.
`include "usrc_map.svh"
`timescale 1ns/1ps
module usrc_assertions
   import usrc_pkg::*;
#(
   parameter int IDLE_CYC = 20,
   parameter int RWU_CYC  = 8
) (
   // Clock and reset
   input wire logic       I_REF_CLK,
   input wire logic       I_RST,
   // Firmware link
   input wire usrc_addr_t addr,
   input wire usrc_byte_t wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic       sleep,
   input wire logic       irq,
   input wire usrc_byte_t rdata,
   // Device pins
   input wire logic       I_BUS_IDLE,
   input wire logic       I_HOST_RESUME,
   input wire logic       I_TXN_START,
   input wire logic       I_EXT_IRQ_ZERO,
   input wire logic       I_EXT_IRQ_ONE,
   input wire logic       I_WAKE_PIN_N,
   input wire logic       O_RESUME_DRIVE,
   input wire logic       O_ADDR_ACTIVE,
   input wire logic       O_CONFIGURED,
   input wire logic       O_OSC_EN,
   input wire logic       O_PLL_EN
);
   // ----
   // Helper counters
   // ----
   int   idle_cnt_r;
   int   idle_cnt_nxt;
   int   drv_cnt_r;
   int   drv_cnt_nxt;
   logic cfg_w_r;
   logic cfg_w_nxt;
   logic quiet;
   logic glb_rd;

   assign glb_rd = rd && (addr == `USRC_GLB_ADDR);

   // Any wake source would legally cancel the sleep request
   assign quiet = I_BUS_IDLE && !I_HOST_RESUME && !I_EXT_IRQ_ZERO && !I_EXT_IRQ_ONE
                  && I_WAKE_PIN_N;

   always_comb begin
      idle_cnt_nxt = I_BUS_IDLE ? idle_cnt_r + 1 : 0;
      drv_cnt_nxt  = O_RESUME_DRIVE ? drv_cnt_r + 1 : 0;
      cfg_w_nxt    = (wr && addr == `USRC_GLB_ADDR) ? wdata[`USRC_GLB_CFG_BIT] : cfg_w_r;
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         idle_cnt_r <= 0;
         drv_cnt_r  <= 0;
         cfg_w_r    <= 1'b0;
      end else begin
         idle_cnt_r <= idle_cnt_nxt;
         drv_cnt_r  <= drv_cnt_nxt;
         cfg_w_r    <= cfg_w_nxt;
      end
   end

   // ----
   // Properties
   // ----
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);

   clk_pair_a: assert property (O_OSC_EN == O_PLL_EN)
      else $error("oscillator and pll enables differ");
   osc_off_sleep_a: assert property ($fell(O_OSC_EN) |-> $past(sleep))
      else $error("oscillator stopped without sleep");
   sleep_gate_a: assert property (sleep && quiet && O_OSC_EN |=> !O_OSC_EN)
      else $error("sleep did not stop oscillator");
   idle_span_a: assert property ($fell(O_OSC_EN) |-> idle_cnt_r >= IDLE_CYC)
      else $error("suspend before idle span");
   host_wake_a: assert property (I_HOST_RESUME && !O_OSC_EN |-> ##[1:2] O_OSC_EN)
      else $error("host resume did not restart oscillator");
   drive_len_a: assert property ($fell(O_RESUME_DRIVE) |-> drv_cnt_r == RWU_CYC)
      else $error("resume drive length wrong");
   addr_apply_a: assert property ($rose(O_ADDR_ACTIVE) |-> $past(I_TXN_START))
      else $error("address applied outside transaction start");
   cfg_write_a: assert property (wr && addr == `USRC_GLB_ADDR |-> ##2 O_CONFIGURED == cfg_w_r)
      else $error("configured flag not as written");
   irq_hold_a: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
      else $error("interrupt dropped without clearing write");
   glb_rsvd_a: assert property (glb_rd |=> rdata[7:5] == 3'h0 && !rdata[2])
      else $error("reserved global state bits not zero");
   susp_flag_a: assert property (glb_rd && sleep && quiet |=> rdata[`USRC_GLOBAL_SUSPEND_EVENT_BIT])
      else $error("suspend indicator clear while suspended");
   res_flag_a: assert property (glb_rd && O_RESUME_DRIVE |=> rdata[`USRC_GLB_RES_BIT])
      else $error("resume indicator clear during resume drive");

   sleep_c: cover property ($fell(O_OSC_EN));
   drive_c: cover property ($rose(O_RESUME_DRIVE));
   addr_c: cover property ($rose(O_ADDR_ACTIVE));
   res_rd_c: cover property (glb_rd && O_RESUME_DRIVE);
endmodule : usrc_assertions

// file: verif/usb_suspend_resume_ctrl_test.sv
// Self-checking bench: device and firmware ends joined by usrc_if.
// Assumes design files and usrc_map.svh compiled first; short counts.
`include "usrc_map.svh"
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module usb_suspend_resume_ctrl_test;
   import usrc_pkg::*;
   // Short counts keep the run brief
   localparam int IDLE_T = 20;
   localparam int RWU_T  = 8;
   logic       I_REF_CLK, I_RST, I_BUS_IDLE, I_HOST_RESUME, I_TXN_START;
   logic       I_EXT_IRQ_ZERO, I_EXT_IRQ_ONE, I_WAKE_PIN_N, I_SET_CONFIG;
   logic       I_ADDR_DONE, I_USE_WAKE_PIN, O_RESUME_DRIVE, O_ADDR_ACTIVE;
   logic       O_CONFIGURED, O_OSC_EN, O_PLL_EN, O_BUSY, O_PERIPH_EN;
   logic       O_GPIO_LOWPWR, O_SLEEP_EN;
   logic [1:0] O_SLEEP_MODE;
   logic [7:0] I_CONFIG_VALUE;
   int         error_cnt = 0;
   int         comparisons = 0;

   usrc_if u_if ();
   usrc_dev #(.IDLE_CYC(IDLE_T), .RWU_CYC(RWU_T)) i_usrc_dev (.I_REF_CLK(I_REF_CLK),
      .I_RST(I_RST), .FW(u_if.dev), .I_BUS_IDLE(I_BUS_IDLE), .I_HOST_RESUME(I_HOST_RESUME),
      .I_TXN_START(I_TXN_START), .O_RESUME_DRIVE(O_RESUME_DRIVE),
      .O_ADDR_ACTIVE(O_ADDR_ACTIVE), .O_CONFIGURED(O_CONFIGURED),
      .I_EXT_IRQ_ZERO(I_EXT_IRQ_ZERO), .I_EXT_IRQ_ONE(I_EXT_IRQ_ONE),
      .I_WAKE_PIN_N(I_WAKE_PIN_N), .O_OSC_EN(O_OSC_EN), .O_PLL_EN(O_PLL_EN));
   usrc_fw i_usrc_fw (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .DEV(u_if.fw),
      .I_SET_CONFIG(I_SET_CONFIG), .I_CONFIG_VALUE(I_CONFIG_VALUE),
      .I_ADDR_DONE(I_ADDR_DONE), .I_USE_WAKE_PIN(I_USE_WAKE_PIN), .O_BUSY(O_BUSY),
      .O_PERIPH_EN(O_PERIPH_EN), .O_GPIO_LOWPWR(O_GPIO_LOWPWR), .O_SLEEP_EN(O_SLEEP_EN),
      .O_SLEEP_MODE(O_SLEEP_MODE));
   usrc_assertions #(.IDLE_CYC(IDLE_T), .RWU_CYC(RWU_T)) i_usrc_assertions (
      .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .addr(u_if.addr), .wdata(u_if.wdata),
      .wr(u_if.wr), .rd(u_if.rd), .sleep(u_if.sleep), .irq(u_if.irq),
      .rdata(u_if.rdata), .I_BUS_IDLE(I_BUS_IDLE),
      .I_HOST_RESUME(I_HOST_RESUME), .I_TXN_START(I_TXN_START),
      .I_EXT_IRQ_ZERO(I_EXT_IRQ_ZERO), .I_EXT_IRQ_ONE(I_EXT_IRQ_ONE),
      .I_WAKE_PIN_N(I_WAKE_PIN_N), .O_RESUME_DRIVE(O_RESUME_DRIVE),
      .O_ADDR_ACTIVE(O_ADDR_ACTIVE), .O_CONFIGURED(O_CONFIGURED), .O_OSC_EN(O_OSC_EN),
      .O_PLL_EN(O_PLL_EN));

   // ----
   // Tasks
   // ----
   function automatic logic exp_cfg(input logic [7:0] v);
      return v != 8'h00;
   endfunction : exp_cfg

   // Inputs always change 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge I_REF_CLK);
      #1;
   endtask : step

   task automatic wait_on(ref logic s, input logic v, input int lim, output int k);
      k = 0;
      while (s !== v && k < lim) begin
         step(1);
         k++;
      end
      `CHK(s, v)
   endtask : wait_on

   task automatic enter_sleep(input logic pin);
      int cnt;
      I_USE_WAKE_PIN = pin;
      I_BUS_IDLE = 1'b1;
      wait_on(u_if.irq, 1'b1, IDLE_T + 5, cnt);
      `CHK(cnt inside {[IDLE_T - 1:IDLE_T + 2]}, 1'b1)
      wait_on(O_OSC_EN, 1'b0, 100, cnt);
      `CHK({O_PLL_EN, O_PERIPH_EN, O_SLEEP_EN, O_GPIO_LOWPWR}, 4'h3)
      `CHK(O_SLEEP_MODE, `USRC_SM_PDOWN)
   endtask : enter_sleep

   task automatic wrap_up;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   // ----
   // Stimulus
   // ----
   initial begin
      I_REF_CLK = 1'b0;
      forever #2.5 I_REF_CLK = ~I_REF_CLK;
   end

   initial begin
      repeat (4000) @(posedge I_REF_CLK);
      error_cnt++;
      wrap_up;
   end

   initial begin : main
      int         cnt;
      logic [7:0] cv;
      {I_BUS_IDLE, I_HOST_RESUME, I_TXN_START, I_EXT_IRQ_ZERO, I_EXT_IRQ_ONE} = 5'h00;
      {I_SET_CONFIG, I_ADDR_DONE, I_USE_WAKE_PIN, I_CONFIG_VALUE} = 11'h000;
      I_WAKE_PIN_N = 1'b1;
      I_RST = 1'b1;
      void'($urandom(8));
      step(10);
      I_RST = 1'b0;
      step(1);
      `CHK({O_OSC_EN, O_PLL_EN, O_PERIPH_EN}, 3'h7)
      `CHK({O_CONFIGURED, O_ADDR_ACTIVE, O_RESUME_DRIVE, u_if.irq}, 4'h0)
      // Zero value at fixed places clears the flag again
      for (int i = 0; i < 6; i++) begin
         cv = (i == 2 || i == 5) ? 8'h00 : 8'($urandom_range(1, 255));
         I_CONFIG_VALUE = cv;
         I_SET_CONFIG = 1'b1;
         step(1);
         I_SET_CONFIG = 1'b0;
         step(3);
         wait_on(O_BUSY, 1'b0, 50, cnt);
         step(2);
         `CHK(O_CONFIGURED, exp_cfg(cv))
      end
      I_ADDR_DONE = 1'b1;
      step(1);
      I_ADDR_DONE = 1'b0;
      step(5);
      `CHK(O_ADDR_ACTIVE, 1'b0)
      I_TXN_START = 1'b1;
      step(1);
      I_TXN_START = 1'b0;
      `CHK(O_ADDR_ACTIVE, 1'b1)
      enter_sleep(1'b0);
      I_HOST_RESUME = 1'b1;
      I_BUS_IDLE = 1'b0;
      step(2);
      `CHK({O_OSC_EN, O_PLL_EN}, 2'h3)
      step($urandom_range(2, 10));
      I_HOST_RESUME = 1'b0;
      wait_on(O_PERIPH_EN, 1'b1, 200, cnt);
      `CHK({O_SLEEP_EN, O_GPIO_LOWPWR, O_RESUME_DRIVE}, 3'h0)
      enter_sleep(1'b1);
      step($urandom_range(1, 30));
      I_WAKE_PIN_N = 1'b0;
      wait_on(O_RESUME_DRIVE, 1'b1, 3, cnt);
      `CHK(O_OSC_EN, 1'b1)
      I_WAKE_PIN_N = 1'b1;
      I_BUS_IDLE = 1'b0;
      wait_on(O_RESUME_DRIVE, 1'b0, RWU_T + 3, cnt);
      `CHK(cnt, RWU_T)
      wait_on(O_PERIPH_EN, 1'b1, 200, cnt);
      enter_sleep(1'b0);
      I_EXT_IRQ_ONE = 1'($urandom_range(0, 1));
      I_EXT_IRQ_ZERO = !I_EXT_IRQ_ONE;
      wait_on(O_OSC_EN, 1'b1, 3, cnt);
      `CHK(O_RESUME_DRIVE, 1'b1)
      wrap_up;
   end
endmodule : usb_suspend_resume_ctrl_test
